// File: ept_pkg.sv
// Package for the timestamp timer and transmit kick block.
// Assumes an APB master with 32-bit data and one clock mclk.
package ept_pkg;

   // ==========================================================
   // Sizes
   localparam int NCH = 4;
   localparam int ADDR_W = 8;
   localparam int INC_W = 7;
   localparam int RING_AW = 3;
   localparam int IRQ_W = NCH + 1;

   // ==========================================================
   // Register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_TMR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_TMR_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_TMR_PERIOD = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_TMR_INC = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_TX_KICK = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h1C;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h20;
   // Channel n: control/status at 0x40+8n, compare at 0x44+8n
   localparam logic [2:0] ADDR_CH_PAGE = 3'h2;

   // ==========================================================
   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PERIODIC_BIT = 1;
   localparam int CTRL_PERSEEN_BIT = 2;
   localparam int CSR_MODE_LSB = 2;
   localparam int CSR_IRQ_EN_BIT = 6;
   localparam int CSR_FLAG_BIT = 7;
   localparam int KICK_BIT = 0;
   localparam int EVENT_FRAME_BIT = 0;
   localparam int IRQ_FRAME_BIT = NCH;

   // ==========================================================
   // Encodings and reset values
   localparam logic [3:0] CH_MODE_OC_SW = 4'h4;
   localparam logic [7:0] CHAN_IRQ_VECTOR = 8'h5B;
   localparam logic [7:0] NO_VECTOR = 8'h00;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } ept_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ept_apb_rsp_t;

   typedef struct packed {
      logic valid;
      logic readyBit;
   } ept_desc_rsp_t;

   typedef struct packed {
      logic fetchReq;
      logic sendReq;
      logic [RING_AW-1:0] index;
   } ept_tx_req_t;

   typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND} ept_tx_state_t;

   typedef struct packed {
      ept_apb_rsp_t rsp;
      logic tmrEn;
      logic periodic_event_enable;
      logic perSeen;
      logic [31:0] count;
      logic [31:0] period;
      logic [INC_W-1:0] inc;
      logic [NCH-1:0][3:0] mode;
      logic [NCH-1:0] chIrqEn;
      logic [NCH-1:0] chFlag;
      logic [NCH-1:0][31:0] cmpAct;
      logic [NCH-1:0][31:0] cmpBuf;
      logic [NCH-1:0] gstat;
      logic kick;
      logic frameFlag;
      logic [IRQ_W-1:0] ists;
      logic [IRQ_W-1:0] imask;
      logic irq;
      logic chanIrq;
      logic [7:0] vec;
      ept_tx_state_t txs;
      logic [RING_AW-1:0] ringIdx;
      ept_tx_req_t txReq;
   } ept_state_t;

   localparam ept_state_t EPT_STATE_RST = '0;

endpackage

// File: ept_ring_model.sv
// Descriptor fetch and frame send partner for the transmit kick logic.
// Assumes txReq from the block on mclk; answers lag+1 cycles after a request.
`timescale 1ns/1ps
`default_nettype none

module ept_ring_model
   import ept_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire ept_tx_req_t txReq,
   input wire logic [7:0] readyMap,
   input wire logic [3:0] lag,
   output ept_desc_rsp_t descRsp,
   output logic frameDone
);
   logic [3:0] waitCnt;
   logic toggle;

   // ==========================================================
   // Answer one request at a time; ready bit junk outside valid
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         waitCnt <= 4'h0;
         toggle <= 1'b0;
         descRsp <= '0;
         frameDone <= 1'b0;
      end else begin
         toggle <= ~toggle;
         descRsp.valid <= 1'b0;
         descRsp.readyBit <= toggle;
         frameDone <= 1'b0;
         if ((txReq.fetchReq || txReq.sendReq) && !descRsp.valid &&
             !frameDone) begin
            if (waitCnt == lag) begin
               waitCnt <= 4'h0;
               if (txReq.fetchReq) begin
                  descRsp.valid <= 1'b1;
                  descRsp.readyBit <= readyMap[txReq.index];
               end else begin
                  frameDone <= 1'b1;
               end
            end else begin
               waitCnt <= waitCnt + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: ept_timer_tx_kick.sv
// Timestamp timer with compare channels and transmit ring kick.
// Assumes APB master on mclk; descriptor engine signals on mclk.
//
// Notes on behaviour
// - Counter equal to period sets periodic flag
// - Period match alone never raises an interrupt
// - Mode 0100 compares; enable bit raises interrupt
// - Compare value double buffered inside device
// - Control has periodic enable and timer enable
// - Channel interrupts use vector number 91
// - Compare sets channel and global flags
// - Clear ready bit stops ring, clears kick
// - Kick write while set is ignored
// - Kick zero-to-one restarts at current position
// - Frame completion sets transmit frame flag
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module ept_timer_tx_kick
   import ept_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire ept_apb_req_t apbReq,
   output ept_apb_rsp_t apbRsp,
   input wire ept_desc_rsp_t descRsp,
   input wire logic frameDone,
   output ept_tx_req_t txReq,
   output logic irq,
   output logic chanIrq,
   output logic [7:0] chanIrqVector
);

   // ==========================================================
   // Address decode
   // Returns {hit, isCompare, index}
   function automatic logic [3:0] chanDecode(
      input logic [ADDR_W-1:0] a);
      chanDecode = {(a[7:5] == ADDR_CH_PAGE) && (a[1:0] == 2'h0),
         a[2], a[4:3]};
   endfunction

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      logic [3:0] cd;
      cd = chanDecode(a);
      case (a)
         ADDR_TMR_CTRL, ADDR_TMR_COUNT, ADDR_TMR_PERIOD, ADDR_TMR_INC,
         ADDR_GLOBAL_STAT, ADDR_TX_KICK, ADDR_EVENT, ADDR_IRQ_STATUS,
         ADDR_IRQ_MASK: isMapped = 1'b1;
         default: isMapped = cd[3];
      endcase
   endfunction

   ept_state_t r_reg;
   ept_state_t r_next;

   logic setupPh;
   logic accessDone;
   logic wrDone;
   logic rdDone;
   logic perHit;
   logic [NCH-1:0] cmpHit;
   logic [3:0] cdec;

   assign setupPh = apbReq.psel && !apbReq.penable && !r_reg.rsp.pready;
   assign accessDone = apbReq.psel && apbReq.penable && r_reg.rsp.pready;
   assign wrDone = accessDone && apbReq.pwrite;
   assign rdDone = accessDone && !apbReq.pwrite;
   assign cdec = chanDecode(apbReq.paddr);
   assign perHit = r_reg.tmrEn && (r_reg.count == r_reg.period);

   // ==========================================================
   // Next state
   always_comb begin
      logic [31:0] rd;
      logic [1:0] ci;
      r_next = r_reg;
      rd = RDATA_ZERO;
      ci = cdec[1:0];
      r_next.rsp.pready = 1'b0;
      r_next.rsp.pslverr = 1'b0;

      // Read data
      case (apbReq.paddr)
         ADDR_TMR_CTRL: begin
            rd[CTRL_EN_BIT] = r_reg.tmrEn;
            rd[CTRL_PERIODIC_BIT] = r_reg.periodic_event_enable;
            rd[CTRL_PERSEEN_BIT] = r_reg.perSeen;
         end
         ADDR_TMR_COUNT: rd = r_reg.count;
         ADDR_TMR_PERIOD: rd = r_reg.period;
         ADDR_TMR_INC: rd[INC_W-1:0] = r_reg.inc;
         ADDR_GLOBAL_STAT: rd[NCH-1:0] = r_reg.gstat;
         ADDR_TX_KICK: rd[KICK_BIT] = r_reg.kick;
         ADDR_EVENT: rd[EVENT_FRAME_BIT] = r_reg.frameFlag;
         ADDR_IRQ_STATUS: rd[IRQ_W-1:0] = r_reg.ists;
         ADDR_IRQ_MASK: rd[IRQ_W-1:0] = r_reg.imask;
         default: begin
            if (cdec[3] && cdec[2]) begin
               rd = r_reg.cmpAct[ci];
            end else if (cdec[3]) begin
               rd[CSR_MODE_LSB +: 4] = r_reg.mode[ci];
               rd[CSR_IRQ_EN_BIT] = r_reg.chIrqEn[ci];
               rd[CSR_FLAG_BIT] = r_reg.chFlag[ci];
            end
         end
      endcase

      // Bus answer one cycle after setup
      if (setupPh) begin
         r_next.rsp.pready = 1'b1;
         r_next.rsp.pslverr = !isMapped(apbReq.paddr);
         r_next.rsp.prdata = isMapped(apbReq.paddr) ? rd : RDATA_ZERO;
      end

      // Register writes, before hardware events so sets win
      if (wrDone) begin
         case (apbReq.paddr)
            ADDR_TMR_CTRL: begin
               r_next.tmrEn = apbReq.pwdata[CTRL_EN_BIT];
               r_next.periodic_event_enable = apbReq.pwdata[CTRL_PERIODIC_BIT];
               if (apbReq.pwdata[CTRL_PERSEEN_BIT]) begin
                  r_next.perSeen = 1'b0;
               end
            end
            ADDR_TMR_PERIOD: r_next.period = apbReq.pwdata;
            ADDR_TMR_INC: r_next.inc = apbReq.pwdata[INC_W-1:0];
            ADDR_GLOBAL_STAT: begin
               r_next.gstat = r_reg.gstat & ~apbReq.pwdata[NCH-1:0];
            end
            ADDR_TX_KICK: begin
               // Only a rising kick acts; writes while set are dropped
               if (apbReq.pwdata[KICK_BIT] && !r_reg.kick) begin
                  r_next.kick = 1'b1;
               end
            end
            ADDR_EVENT: begin
               if (apbReq.pwdata[EVENT_FRAME_BIT]) begin
                  r_next.frameFlag = 1'b0;
               end
            end
            ADDR_IRQ_MASK: r_next.imask = apbReq.pwdata[IRQ_W-1:0];
            default: begin
               if (cdec[3] && cdec[2]) begin
                  // Two-stage shift: two writes fill both stages
                  r_next.cmpAct[ci] = r_reg.cmpBuf[ci];
                  r_next.cmpBuf[ci] = apbReq.pwdata;
               end else if (cdec[3]) begin
                  r_next.mode[ci] = apbReq.pwdata[CSR_MODE_LSB +: 4];
                  r_next.chIrqEn[ci] = apbReq.pwdata[CSR_IRQ_EN_BIT];
                  if (apbReq.pwdata[CSR_FLAG_BIT]) begin
                     r_next.chFlag[ci] = 1'b0;
                  end
               end
            end
         endcase
      end

      // Interrupt status clears on read
      if (rdDone && apbReq.paddr == ADDR_IRQ_STATUS) begin
         r_next.ists = '0;
      end

      // Timestamp counter
      if (r_reg.tmrEn) begin
         r_next.count = perHit ? 32'h0000_0000 :
            r_reg.count + 32'(r_reg.inc);
      end
      // Period flag is visible only; no interrupt source feeds from it
      if (perHit && r_reg.periodic_event_enable) begin
         r_next.perSeen = 1'b1;
      end

      // Compare channels
      for (int i = 0; i < NCH; i++) begin
         cmpHit[i] = r_reg.tmrEn && (r_reg.mode[i] == CH_MODE_OC_SW)
            && (r_reg.count == r_reg.cmpAct[i]);
         if (cmpHit[i]) begin
            r_next.chFlag[i] = 1'b1;
            r_next.gstat[i] = 1'b1;
            r_next.cmpAct[i] = r_reg.cmpBuf[i];
            if (r_reg.chIrqEn[i]) begin
               r_next.ists[i] = 1'b1;
            end
         end
      end

      // Transmit descriptor engine
      case (r_reg.txs)
         TX_IDLE: begin
            if (r_reg.kick) begin
               r_next.txReq.fetchReq = 1'b1;
               r_next.txs = TX_FETCH;
            end
         end
         TX_FETCH: begin
            if (descRsp.valid) begin
               r_next.txReq.fetchReq = 1'b0;
               if (descRsp.readyBit) begin
                  r_next.txReq.sendReq = 1'b1;
                  r_next.txs = TX_SEND;
               end else begin
                  r_next.kick = 1'b0;
                  r_next.txs = TX_IDLE;
               end
            end
         end
         TX_SEND: begin
            if (frameDone) begin
               r_next.txReq.sendReq = 1'b0;
               r_next.ringIdx = r_reg.ringIdx + RING_AW'(1);
               r_next.frameFlag = 1'b1;
               r_next.ists[IRQ_FRAME_BIT] = 1'b1;
               r_next.txs = TX_IDLE;
            end
         end
         default: r_next.txs = TX_IDLE;
      endcase
      r_next.txReq.index = r_next.ringIdx;

      // Interrupt outputs
      r_next.irq = |(r_next.ists & r_next.imask);
      r_next.chanIrq = |(r_next.ists[NCH-1:0] & r_next.imask[NCH-1:0]);
      r_next.vec = r_next.chanIrq ? CHAN_IRQ_VECTOR : NO_VECTOR;
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= EPT_STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign apbRsp = r_reg.rsp;
   assign txReq = r_reg.txReq;
   assign irq = r_reg.irq;
   assign chanIrq = r_reg.chanIrq;
   assign chanIrqVector = r_reg.vec;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_cmp_hit0;
      r_reg.tmrEn && r_reg.mode[0] == CH_MODE_OC_SW
         && r_reg.count == r_reg.cmpAct[0];
   endsequence

   sequence s_kick_rise;
      wrDone && apbReq.paddr == ADDR_TX_KICK
         && apbReq.pwdata[KICK_BIT] && !r_reg.kick;
   endsequence

   a_period_flag: assert property (perHit && r_reg.periodic_event_enable |=> r_reg.perSeen)
      else $error("period match did not set flag");
   a_period_noirq: assert property (perHit && !(|cmpHit)
      && r_reg.txs != TX_SEND && !rdDone |=> r_reg.ists == $past(r_reg.ists))
      else $error("period match changed interrupt status");
   a_count_wrap: assert property (perHit |=> r_reg.count == 32'h0000_0000)
      else $error("counter did not wrap at period");
   a_count_step: assert property (r_reg.tmrEn && !perHit
      |=> r_reg.count == $past(r_reg.count) + 32'($past(r_reg.inc)))
      else $error("counter did not advance by increment");
   a_cmp_flags: assert property (s_cmp_hit0
      |=> r_reg.chFlag[0] && r_reg.gstat[0])
      else $error("compare did not set channel flags");
   a_cmp_irq: assert property (s_cmp_hit0 and r_reg.chIrqEn[0]
      && r_reg.imask[0]
      |=> ##1 irq && chanIrq)
      else $error("compare interrupt not raised");
   a_cmp_reload: assert property (s_cmp_hit0
      |=> r_reg.cmpAct[0] == $past(r_reg.cmpBuf[0]))
      else $error("active compare not reloaded");
   a_vector_fixed: assert property (chanIrq |-> chanIrqVector == 8'h5B)
      else $error("wrong channel interrupt vector");
   a_ready_stop: assert property (r_reg.txs == TX_FETCH && descRsp.valid
      && !descRsp.readyBit |=> !r_reg.kick && r_reg.txs == TX_IDLE)
      else $error("clear ready bit did not stop ring");
   a_kick_ignored: assert property (wrDone && apbReq.paddr == ADDR_TX_KICK
      && r_reg.kick && r_reg.txs == TX_FETCH && descRsp.valid
      && !descRsp.readyBit |=> !r_reg.kick)
      else $error("kick write while set took effect");
   a_kick_restart: assert property (s_kick_rise
      |=> r_reg.kick ##1 txReq.fetchReq
      && txReq.index == $past(r_reg.ringIdx, 2))
      else $error("kick did not restart at ring position");
   a_frame_flag: assert property (r_reg.txs == TX_SEND && frameDone
      |=> r_reg.frameFlag && r_reg.ists[IRQ_FRAME_BIT])
      else $error("frame done flag not set");
   a_apb_answer: assert property (setupPh |=> apbRsp.pready ##1 !apbRsp.pready)
      else $error("bus answer not one cycle");

   // ==========================================================
   // Bus refusal and hold
   a_unmapped_err: assert property (setupPh && !isMapped(apbReq.paddr)
      |=> apbRsp.pslverr && apbRsp.prdata == RDATA_ZERO)
      else $error("unmapped access not refused");
   a_rdata_hold: assert property (!setupPh |=> $stable(apbRsp.prdata))
      else $error("read data moved outside answer");
   a_ready_idle: assert property (!setupPh |=> !apbRsp.pready)
      else $error("bus answer without setup");

   // ==========================================================
   // Timer and channel gating
   a_timer_hold: assert property (!r_reg.tmrEn
      |=> r_reg.count == $past(r_reg.count))
      else $error("stopped counter moved");
   a_per_gate: assert property (perHit && !r_reg.periodic_event_enable && !wrDone
      |=> r_reg.perSeen == $past(r_reg.perSeen))
      else $error("period flag set while disabled");
   a_mode_gate: assert property (r_reg.mode[0] != CH_MODE_OC_SW
      |=> !$rose(r_reg.gstat[0]))
      else $error("compare fired outside compare mode");
   a_gstat_clear: assert property (wrDone && apbReq.paddr == ADDR_GLOBAL_STAT
      && apbReq.pwdata[0] && !cmpHit[0] |=> !r_reg.gstat[0])
      else $error("global channel flag not cleared");
   a_flag_clear: assert property (wrDone && apbReq.paddr == 8'h40
      && apbReq.pwdata[CSR_FLAG_BIT] && !cmpHit[0]
      |=> !r_reg.chFlag[0])
      else $error("channel flag not cleared");
   a_vector_idle: assert property (!chanIrq
      |-> chanIrqVector == 8'h00)
      else $error("vector shown without channel interrupt");

   // ==========================================================
   // Transmit ring
   a_stop_index: assert property (r_reg.txs == TX_FETCH && descRsp.valid
      && !descRsp.readyBit |=> txReq.index == $past(r_reg.ringIdx))
      else $error("ring position moved on stop");
   a_kick_zero: assert property (wrDone && apbReq.paddr == ADDR_TX_KICK
      && !apbReq.pwdata[KICK_BIT] && r_reg.txs != TX_FETCH
      |=> r_reg.kick == $past(r_reg.kick))
      else $error("kick write of zero took effect");
   a_send_start: assert property (r_reg.txs == TX_FETCH && descRsp.valid
      && descRsp.readyBit |=> txReq.sendReq && !txReq.fetchReq)
      else $error("ready descriptor not sent");
   a_frame_index: assert property (r_reg.txs == TX_SEND && frameDone
      |=> r_reg.ringIdx == $past(r_reg.ringIdx) + 3'h1)
      else $error("ring position not advanced");

endmodule

`default_nettype wire

// File: test_ethernet_controller_ptp_timer_tx_kick.sv
// Self-checking bench for the timestamp timer and transmit kick block.
// Assumes ept_pkg, the block and ept_ring_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_ethernet_controller_ptp_timer_tx_kick
   import ept_pkg::*;
;
   localparam logic [31:0] PER = 32'h12C;
   localparam logic [31:0] INC = 32'h3;
   logic mclk;
   logic rstn;
   ept_apb_req_t apbReq;
   ept_apb_rsp_t apbRsp;
   ept_desc_rsp_t descRsp;
   logic frameDone;
   ept_tx_req_t txReq;
   logic irq;
   logic chanIrq;
   logic [7:0] chanIrqVector;
   logic [7:0] readyMap;
   logic [3:0] lag;
   logic [31:0] rd;
   logic err;
   int failCount = 0;
   int samplesChecked = 0;
   int doneCount = 0;

   ept_timer_tx_kick u_dut (.mclk(mclk), .rstn(rstn), .apbReq(apbReq),
      .apbRsp(apbRsp), .descRsp(descRsp), .frameDone(frameDone),
      .txReq(txReq), .irq(irq), .chanIrq(chanIrq),
      .chanIrqVector(chanIrqVector));
   ept_ring_model u_ring (.mclk(mclk), .rstn(rstn), .txReq(txReq),
      .readyMap(readyMap), .lag(lag), .descRsp(descRsp),
      .frameDone(frameDone));

   initial mclk = 1'b0;
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      if (frameDone === 1'b1 && txReq.sendReq === 1'b1) begin
         doneCount <= doneCount + 1;
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      samplesChecked++;
      if (seen !== exp) begin
         failCount++;
         $display("unexpected %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask

   task automatic bail(input int n, input int limit);
      if (n > limit) begin
         check(32'h0, 32'h1, "wait ran out");
         report_and_stop();
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= w;
      apbReq.paddr <= a;
      apbReq.pwdata <= d;
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      @(posedge mclk);
      while (apbRsp.pready !== 1'b1) begin
         n++;
         bail(n, 20);
         @(posedge mclk);
      end
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
      apb(1'b0, a, 32'h0);
      check(rd, exp, what);
   endtask

   task automatic waitChan();
      int n;
      n = 0;
      while (chanIrq !== 1'b1) begin
         @(posedge mclk);
         n++;
         bail(n, 400);
      end
   endtask

   task automatic waitStop();
      int n;
      n = 0;
      rd = 32'h1;
      while (rd !== 32'h0) begin
         apb(1'b0, ADDR_TX_KICK, 32'h0);
         n++;
         bail(n, 40);
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic resetValues();
      rdc(ADDR_TMR_CTRL, 32'h0, "ctrl");
      rdc(8'h40, 32'h0, "ch0 csr");
      rdc(8'h48, 32'h0, "ch1 csr");
      rdc(ADDR_TX_KICK, 32'h0, "kick");
      check({31'h0, txReq.fetchReq}, 32'h0, "fetch idle");
      apb(1'b0, 8'hFC, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped");
   endtask

   task automatic timerRun();
      logic [31:0] v;
      wr(ADDR_IRQ_MASK, 32'h1F);
      wr(ADDR_TMR_INC, INC);
      wr(ADDR_TMR_PERIOD, PER);
      wr(ADDR_TMR_CTRL, 32'h3);
      repeat (120) @(posedge mclk);
      check({31'h0, irq}, 32'h0, "period irq");
      rdc(ADDR_TMR_CTRL, 32'h7, "period seen");
      rdc(ADDR_IRQ_STATUS, 32'h0, "period status");
      wr(ADDR_TMR_CTRL, 32'h0);
      apb(1'b0, ADDR_TMR_COUNT, 32'h0);
      v = rd;
      check(v % INC, 32'h0, "count step");
      check({31'h0, v <= PER}, 32'h1, "count wrap");
      rdc(ADDR_TMR_COUNT, v, "count held");
      wr(ADDR_TMR_CTRL, 32'h5);
      repeat (120) @(posedge mclk);
      rdc(ADDR_TMR_CTRL, 32'h1, "no period event");
   endtask

   task automatic compareChannel();
      wr(ADDR_TMR_CTRL, 32'h0);
      wr(8'h44, PER - INC);
      wr(8'h4C, PER - INC);
      wr(8'h40, 32'h50);
      wr(8'h48, 32'h4C);
      wr(8'h44, PER - INC);
      wr(8'h4C, PER - INC);
      wr(ADDR_TMR_CTRL, 32'h1);
      waitChan();
      check({24'h0, chanIrqVector}, 32'h5B, "vector");
      check({31'h0, irq}, 32'h1, "irq");
      rdc(ADDR_GLOBAL_STAT, 32'h1, "global");
      rdc(8'h40, 32'hD0, "ch0 flag");
      rdc(8'h48, 32'h4C, "ch1 quiet");
      rdc(ADDR_IRQ_STATUS, 32'h1, "chan status");
      repeat (2) @(posedge mclk);
      check({31'h0, chanIrq}, 32'h0, "chan irq low");
      wr(8'h44, PER - INC);
      wr(8'h40, 32'hD0);
      wr(ADDR_GLOBAL_STAT, 32'h1);
      rdc(ADDR_GLOBAL_STAT, 32'h0, "global clear");
      rdc(8'h40, 32'h50, "flag clear");
      waitChan();
      rdc(ADDR_GLOBAL_STAT, 32'h1, "second hit");
      wr(ADDR_TMR_CTRL, 32'h0);
      rdc(ADDR_IRQ_STATUS, 32'h1, "status again");
   endtask

   task automatic txKick();
      wr(ADDR_TX_KICK, 32'h1);
      waitStop();
      check(doneCount, 32'h2, "frames");
      check({29'h0, txReq.index}, 32'h2, "stop index");
      check({31'h0, irq}, 32'h1, "frame irq");
      rdc(ADDR_EVENT, 32'h1, "frame flag");
      rdc(ADDR_IRQ_STATUS, 32'h10, "frame status");
      wr(ADDR_EVENT, 32'h1);
      readyMap <= 8'h07;
      lag <= 4'h3;
      repeat (10) @(posedge mclk);
      check({31'h0, txReq.fetchReq}, 32'h0, "no self restart");
      wr(ADDR_TX_KICK, 32'h1);
      waitStop();
      check(doneCount, 32'h3, "restart frames");
      check({29'h0, txReq.index}, 32'h3, "restart index");
   endtask

   initial begin
      apbReq = '0;
      rstn = 1'b0;
      readyMap = 8'h03;
      lag = 4'h0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      resetValues();
      timerRun();
      compareChannel();
      txKick();
      report_and_stop();
   end
endmodule
`default_nettype wire
